/* logic/bmpd_defs.svh */
`ifndef BMPD_DEFS_SVH
`define BMPD_DEFS_SVH

// opcode bytes; the decoder compares ins_op with 11H, CFH and 61H, never with 08H
`define BMPD_PREFIX_OP 8'h11
`define BMPD_ABS_IMM_OP 8'hCF
`define BMPD_XCH_AX_OP 8'h08
`define BMPD_XCH_R_OP 8'h61

// segment used when no prefix is present (F0000H..FFFFFH)
`define BMPD_WIN_SEG 4'hF
`define BMPD_ES_RST 4'hF

// instruction clocks, each one cpu_clock cycle
`define BMPD_CYC_RAM 3'h1
`define BMPD_CYC_PM 3'h4
`define BMPD_CYC_ES_RAM 3'h2
`define BMPD_CYC_ES_PM 3'h5
`define BMPD_CYC_PSW 3'h3
`define BMPD_CYC_XCH_MEM 3'h2
`define BMPD_CYC_ES_XCH_MEM 3'h3

// flag positions inside the program_status_word byte
`define BMPD_PSW_Z 6
`define BMPD_PSW_AC 4
`define BMPD_PSW_CY 0
`define BMPD_FLAGS_RST 3'h0

`endif

/* logic/bmpd_pkg.sv */
package bmpd_pkg;

  typedef enum logic [1:0] {
    BMPD_K_MOVE = 2'b00,
    BMPD_K_XCH = 2'b01,
    BMPD_K_PSW_WR = 2'b10,
    BMPD_K_ES_WR = 2'b11
  } bmpd_kind_t;

  typedef enum logic [0:0] {
    BMPD_S_IDLE = 1'b0,
    BMPD_S_EXEC = 1'b1
  } bmpd_state_t;

endpackage

/* logic/bmpd_cyc_cnt.sv */
`timescale 1ns/10ps
module bmpd_cyc_cnt (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // load
  input wire logic load,
  input wire logic [2:0] load_val,
  // status
  output logic busy,
  output logic last
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic run_r;
  logic run_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (load) begin
      cnt_nxt = load_val - 3'h1;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == 3'h0) begin
        run_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= 3'h0;
      run_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  assign busy = run_r;
  assign last = run_r && (cnt_r == 3'h0);

endmodule

/* logic/bmpd_decoder.sv */
`timescale 1ns/10ps
`include "bmpd_defs.svh"
// Summary of operation
// - a prefixed instruction addresses {extension segment, 16-bit address}, others use F0000H-FFFFFH.
// - the segment extension covers only the one instruction right after the prefix byte.
// - the prefix is the leading byte 11H ahead of an unchanged encoding such as CFH.
// - unprefixed transfers take 1 clock for RAM/SFR or no data, 4 for a program memory load.
// - prefixed transfers take 2 clocks for RAM/SFR data and 5 for a program memory load.
// - each instruction clock is exactly one cpu_clock cycle.
module bmpd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // instruction from fetch
  input wire logic ins_valid,
  input wire logic [7:0] ins_op,
  input wire bmpd_pkg::bmpd_kind_t ins_kind,
  input wire logic [15:0] ins_addr,
  input wire logic ins_mem,
  input wire logic ins_pm,
  input wire logic ins_load,
  input wire logic [7:0] ins_data,
  // decode results
  output logic busy_r,
  output logic done_r,
  output logic addr_valid_r,
  output logic [19:0] data_addr_r,
  output logic prefixed_r,
  output logic [2:0] cycles_r,
  output logic xch_r,
  output logic xch_two_byte_r,
  output logic pm_store_r,
  output logic abs_imm_r,
  // architectural state
  output logic [3:0] extension_segment_register_r,
  output logic zero_flag_r,
  output logic auxiliary_carry_flag_r,
  output logic carry_flag_r
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] bmpd_cycles(input bmpd_pkg::bmpd_kind_t k, input logic pre,
                                             input logic mem, input logic pm, input logic ld);
    logic [2:0] c;
    c = pre ? `BMPD_CYC_ES_RAM : `BMPD_CYC_RAM;
    if (k == bmpd_pkg::BMPD_K_PSW_WR) begin
      c = `BMPD_CYC_PSW;
    end else if (k == bmpd_pkg::BMPD_K_XCH) begin
      if (mem) begin
        c = pre ? `BMPD_CYC_ES_XCH_MEM : `BMPD_CYC_XCH_MEM;
      end else begin
        c = `BMPD_CYC_RAM;
      end
    end else if (!mem) begin
      c = `BMPD_CYC_RAM;
    end else if (pm && ld) begin
      c = pre ? `BMPD_CYC_ES_PM : `BMPD_CYC_PM;
    end
    return c;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  bmpd_pkg::bmpd_state_t state_r;
  bmpd_pkg::bmpd_state_t state_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [3:0] es_nxt;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic [19:0] addr_nxt;
  logic addr_valid_nxt;
  logic prefixed_nxt;
  logic [2:0] cycles_nxt;
  logic xch_nxt;
  logic xch_two_nxt;
  logic pm_store_nxt;
  logic abs_imm_nxt;
  logic done_nxt;
  logic cnt_load;
  logic cnt_busy;
  logic cnt_last;
  logic take;

  // the prefix byte itself costs no clock: the prefixed counts already include it
  assign take = ins_valid && !cnt_busy;

  bmpd_cyc_cnt u_cnt (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .load(cnt_load),
    .load_val(cycles_nxt),
    .busy(cnt_busy),
    .last(cnt_last)
  );

  // ----------------------------------------
  // decode and sequencing
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    es_nxt = extension_segment_register_r;
    flags_nxt = flags_r;
    addr_nxt = data_addr_r;
    addr_valid_nxt = 1'b0;
    prefixed_nxt = prefixed_r;
    cycles_nxt = cycles_r;
    xch_nxt = xch_r;
    xch_two_nxt = xch_two_byte_r;
    pm_store_nxt = pm_store_r;
    abs_imm_nxt = abs_imm_r;
    done_nxt = 1'b0;
    cnt_load = 1'b0;
    case (state_r)
      bmpd_pkg::BMPD_S_IDLE: begin
        if (take && ins_op == `BMPD_PREFIX_OP) begin
          pend_nxt = 1'b1;
        end else if (take) begin
          pend_nxt = 1'b0;
          prefixed_nxt = pend_r;
          cycles_nxt = bmpd_cycles(ins_kind, pend_r, ins_mem, ins_pm, ins_load);
          cnt_load = 1'b1;
          addr_valid_nxt = ins_mem;
          // rely on software having loaded the segment first
          addr_nxt = {pend_r ? extension_segment_register_r : `BMPD_WIN_SEG, ins_addr};
          xch_nxt = (ins_kind == bmpd_pkg::BMPD_K_XCH);
          xch_two_nxt = (ins_kind == bmpd_pkg::BMPD_K_XCH) && (ins_op == `BMPD_XCH_R_OP);
          abs_imm_nxt = (ins_op == `BMPD_ABS_IMM_OP);
          // no cycle count exists for stores into program memory; flagged, not blocked
          pm_store_nxt = ins_mem && ins_pm && !ins_load && (ins_kind == bmpd_pkg::BMPD_K_MOVE);
          if (ins_kind == bmpd_pkg::BMPD_K_PSW_WR) begin
            flags_nxt = {ins_data[`BMPD_PSW_Z], ins_data[`BMPD_PSW_AC], ins_data[`BMPD_PSW_CY]};
          end
          if (ins_kind == bmpd_pkg::BMPD_K_ES_WR) begin
            es_nxt = ins_data[3:0];
          end
          state_nxt = bmpd_pkg::BMPD_S_EXEC;
        end
      end
      bmpd_pkg::BMPD_S_EXEC: begin
        if (cnt_last) begin
          done_nxt = 1'b1;
          state_nxt = bmpd_pkg::BMPD_S_IDLE;
        end
      end
      default: begin
        state_nxt = bmpd_pkg::BMPD_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= bmpd_pkg::BMPD_S_IDLE;
      pend_r <= 1'b0;
      extension_segment_register_r <= `BMPD_ES_RST;
      flags_r <= `BMPD_FLAGS_RST;
      data_addr_r <= 20'h00000;
      addr_valid_r <= 1'b0;
      prefixed_r <= 1'b0;
      cycles_r <= 3'h0;
      xch_r <= 1'b0;
      xch_two_byte_r <= 1'b0;
      pm_store_r <= 1'b0;
      abs_imm_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      extension_segment_register_r <= es_nxt;
      flags_r <= flags_nxt;
      data_addr_r <= addr_nxt;
      addr_valid_r <= addr_valid_nxt;
      prefixed_r <= prefixed_nxt;
      cycles_r <= cycles_nxt;
      xch_r <= xch_nxt;
      xch_two_byte_r <= xch_two_nxt;
      pm_store_r <= pm_store_nxt;
      abs_imm_r <= abs_imm_nxt;
      done_r <= done_nxt;
      busy_r <= (state_nxt == bmpd_pkg::BMPD_S_EXEC);
    end
  end

  assign zero_flag_r = flags_r[2];
  assign auxiliary_carry_flag_r = flags_r[1];
  assign carry_flag_r = flags_r[0];

endmodule

/* dv/bmpd_checker.sv */
`timescale 1ns/10ps
module bmpd_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // decode results
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic addr_valid_r,
  input wire logic [19:0] data_addr_r,
  input wire logic prefixed_r,
  input wire logic [2:0] cycles_r,
  input wire logic xch_two_byte_r,
  // state
  input wire logic [3:0] extension_segment_register_r,
  input wire logic zero_flag_r,
  input wire logic auxiliary_carry_flag_r,
  input wire logic carry_flag_r
);
  logic [2:0] cnt_r, cnt_nxt;
  wire logic [2:0] flg = {zero_flag_r, auxiliary_carry_flag_r, carry_flag_r};
  // counts only enabled edges, as the design does
  always_comb begin
    cnt_nxt = busy_r ? cnt_r + 3'h1 : 3'h0;
    if (!ce) cnt_nxt = cnt_r;
  end
  always_ff @(posedge clk) begin
    cnt_r <= nrst ? cnt_nxt : 3'h0;
  end
  // --------
  // properties
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_len; done_r |-> cnt_r == cycles_r; endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_done1; done_r && ce |=> !done_r; endproperty
  a_done1: assert property (p_done1) else $error("done width");
  property p_win; addr_valid_r && !prefixed_r |-> data_addr_r[19:16] == 4'hF; endproperty
  a_win: assert property (p_win) else $error("window");
  property p_seg;
    addr_valid_r && prefixed_r |-> data_addr_r[19:16] == extension_segment_register_r;
  endproperty
  a_seg: assert property (p_seg) else $error("segment");
  property p_pcyc; $rose(busy_r) && prefixed_r |-> cycles_r inside {3'h2, 3'h3, 3'h5}; endproperty
  a_pcyc: assert property (p_pcyc) else $error("prefixed count");
  property p_xch; $rose(busy_r) && xch_two_byte_r |-> cycles_r == 3'h1; endproperty
  a_xch: assert property (p_xch) else $error("exchange count");
  property p_flg; $changed(flg) |-> $rose(busy_r) && cycles_r == 3'h3; endproperty
  a_flg: assert property (p_flg) else $error("flags");
  property p_av; $rose(addr_valid_r) |-> $rose(busy_r); endproperty
  a_av: assert property (p_av) else $error("address pulse");
  c_pm5: cover property ($rose(busy_r) && prefixed_r && cycles_r == 3'h5);
  c_xch: cover property ($rose(busy_r) && xch_two_byte_r);
  c_psw: cover property ($changed(flg));
endmodule
bind bmpd_decoder bmpd_checker i_bmpd_checker (.clk, .nrst, .ce, .busy_r, .done_r,
  .addr_valid_r, .data_addr_r, .prefixed_r, .cycles_r, .xch_two_byte_r,
  .extension_segment_register_r, .zero_flag_r, .auxiliary_carry_flag_r, .carry_flag_r);

/* dv/bmpd_mem_model.sv */
`timescale 1ns/10ps
module bmpd_mem_model (
  // access
  input wire logic clk,
  input wire logic hit,
  input wire logic [19:0] addr,
  // log
  output logic [19:0] last_addr
);
  always_ff @(posedge clk) begin
    if (hit) last_addr <= addr;
  end
endmodule

/* dv/bmpd_decoder_tb_top.sv */
`timescale 1ns/10ps
module bmpd_decoder_tb_top;
  logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, ins_valid = 1'h0, ins_mem = 1'h0;
  logic ins_pm = 1'h0, ins_load = 1'h0, busy_r, done_r, addr_valid_r, prefixed_r, xch_r;
  logic xch_two_byte_r, pm_store_r, abs_imm_r, zero_flag_r, auxiliary_carry_flag_r, carry_flag_r;
  logic [7:0] ins_op = 8'h00, ins_data = 8'h00;
  logic [15:0] ins_addr = 16'h0000;
  bmpd_pkg::bmpd_kind_t ins_kind = bmpd_pkg::BMPD_K_MOVE;
  logic [19:0] data_addr_r, last;
  logic [2:0] cycles_r, fx, ft[3] = '{3'h4, 3'h5, 3'h7}, ct[3] = '{3'h1, 3'h1, 3'h4};
  logic [3:0] extension_segment_register_r, esx = 4'hF;
  logic [24:0] e, q[$];
  logic [31:0] rnd = 32'h41EE;
  int failures = 0, n_tests = 0, bc = 0, k;
  always #2 clk = ~clk;
  bmpd_decoder i_bmpd_decoder (.clk, .nrst, .ce, .ins_valid, .ins_op, .ins_kind, .ins_addr,
    .ins_mem, .ins_pm, .ins_load, .ins_data, .busy_r, .done_r, .addr_valid_r, .data_addr_r,
    .prefixed_r, .cycles_r, .xch_r, .xch_two_byte_r, .pm_store_r, .abs_imm_r,
    .extension_segment_register_r, .zero_flag_r, .auxiliary_carry_flag_r, .carry_flag_r);
  bmpd_mem_model i_bmpd_mem_model (.clk, .hit(addr_valid_r), .addr(data_addr_r), .last_addr(last));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // --------
  // stimulus
  // --------
  task automatic run(input logic [7:0] o, input logic [1:0] kd, input logic [2:0] f,
      input logic [2:0] c, input logic p);
    @(negedge clk);
    rnd = lfsr(rnd);
    ins_op = o;
    ins_kind = bmpd_pkg::bmpd_kind_t'(kd);
    {ins_mem, ins_pm, ins_load, ins_addr, ins_data} = {f, rnd[23:0]};
    ins_valid = 1'h1;
    if (kd == 2'h3) esx = rnd[3:0];
    if (kd == 2'h2) fx = {rnd[6], rnd[4], rnd[0]};
    if (o != 8'h11) q.push_back({f[2], p, c, p ? esx : 4'hF, rnd[23:8]});
    @(negedge clk);
    ins_valid = 1'h0;
    for (k = 0; k < 20 && o != 8'h11 && done_r !== 1'h1; k++) @(negedge clk);
    if (k == 20) begin
      failures++;
      conclude();
    end
  endtask
  // random stalls while an instruction runs
  always @(negedge clk) ce <= !(ce && busy_r === 1'h1 && rnd[1]);
  always @(negedge clk) begin
    if (busy_r === 1'h1 && ce) bc++;
    if (done_r === 1'h1 && q.size() > 0) begin
      e = q.pop_front();
      chk(bc == e[22:20], "busy length");
      chk(prefixed_r === e[23], "prefix");
      if (e[24]) chk(last === e[19:0], "address");
      bc = 0;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'h1;
    run(8'h41, 2'h3, 3'h0, 3'h1, 1'h0);
    for (int i = 0; i < 6; i++) begin
      if (i > 2) run(8'h11, 2'h0, 3'h0, 3'h0, 1'h0);
      run(8'h8B, 2'h0, ft[i % 3], ct[i % 3] + 3'(i / 3), 1'(i / 3));
    end
    run(8'h11, 2'h0, 3'h0, 3'h0, 1'h0);
    run(8'h11, 2'h0, 3'h0, 3'h0, 1'h0);
    run(8'hCF, 2'h0, 3'h4, 3'h2, 1'h1);
    chk(abs_imm_r === 1'h1, "abs store");
    run(8'hCF, 2'h0, 3'h4, 3'h1, 1'h0);
    chk(pm_store_r === 1'h0, "ram store marked");
    run(8'h8E, 2'h0, 3'h6, 3'h1, 1'h0);
    chk(pm_store_r === 1'h1, "pm store unmarked");
    run(8'h08, 2'h1, 3'h0, 3'h1, 1'h0);
    chk(xch_r === 1'h1 && xch_two_byte_r === 1'h0, "exchange x");
    run(8'h61, 2'h1, 3'h0, 3'h1, 1'h0);
    chk(xch_two_byte_r === 1'h1, "exchange r");
    run(8'h4E, 2'h2, 3'h0, 3'h3, 1'h0);
    run(8'h08, 2'h1, 3'h0, 3'h1, 1'h0);
    chk({zero_flag_r, auxiliary_carry_flag_r, carry_flag_r} === fx, "flags");
    conclude();
  end
endmodule
